// ### logic/pvc_regs.sv
// pump current and vco calibration configuration registers with serial port
//
// Functional notes
// - pump down current code, bits 6:0, 20 uA steps, resets to 100
// - pump up current code, bits 13:7, 20 uA steps, resets to 100
// - pump offset magnitude, bits 20:14, 5 uA steps, resets to zero
// - pump register resets to 0x403264, top bit reserved
// - interval code bits 2:0 picks divider cycles, 1 up to 256, reset 5
// - calibration runs while disable bit 11 is zero
// - bit 12 set suppresses internal transfers launched by vco access writes
// - bits 14:13 divide reference by 1, 4, 16 or 32, reset 1
`timescale 1ns/1ps
`include "pvc_map.svh"
module pvc_regs (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_en_i,
  output logic ser_sdo_o,
  output logic ser_sdo_oe_o,
  input wire logic rdiv_tick_i,
  input wire logic meas_start_i,
  output pvc_pkg::pvc_gain_t pump_dn_gain_o,
  output pvc_pkg::pvc_gain_t pump_up_gain_o,
  output pvc_pkg::pvc_gain_t pump_ofs_mag_o,
  output logic pump_ofs_up_en_o,
  output logic pump_ofs_dn_en_o,
  output logic cal_enable_o,
  output logic force_curve_o,
  output logic fsm_tick_o,
  output logic meas_done_o,
  output logic vco_internal_serial_port_xfer_o
);
  import pvc_pkg::*;

  pvc_cal_if cal_bus ();

  logic [2:0] clk_sync_r;
  logic [2:0] en_sync_r;
  logic [1:0] dat_sync_r;
  logic clk_rise;
  logic en_fall;
  pvc_frame_t frame_r;
  logic [5:0] bit_cnt_r;
  logic [7:0] hdr_r;
  pvc_word_t data_r;
  pvc_word_t shout_r;
  pvc_word_t pump_r;
  pvc_word_t vcal_r;
  pvc_word_t rd_word;
  logic sdo_r;
  logic sdo_oe_r;
  logic vco_wr_r;
  logic cal_en_r;
  logic wr_ok;

  // two-flop synchronisers plus a delay stage for edge detection
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      clk_sync_r <= 3'h0;
      en_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[1:0], ser_clk_i};
      en_sync_r <= {en_sync_r[1:0], ser_en_i};
      dat_sync_r <= {dat_sync_r[0], ser_data_i};
    end
  end

  assign clk_rise = clk_sync_r[1] && !clk_sync_r[2];
  assign en_fall = !en_sync_r[1] && en_sync_r[2];

  // header bit 7 is read flag, bits 6:1 address
  assign wr_ok = (frame_r == PVC_DATA) && (bit_cnt_r == `PVC_FRAME_BITS) && !hdr_r[7];

  // read data mux, used one bit early so the address still sits in bits 5:0
  always_comb
  begin
    unique case (hdr_r[5:0])
      `PVC_ADDR_PUMP: rd_word = pump_r;
      `PVC_ADDR_VCAL: rd_word = vcal_r;
      default: rd_word = 24'h000000;
    endcase
  end

  // serial frame sequencer
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      frame_r <= PVC_IDLE;
      bit_cnt_r <= 6'h00;
      hdr_r <= 8'h00;
      data_r <= 24'h000000;
    end
    else
    begin
      unique case (frame_r)
        PVC_IDLE:
        begin
          bit_cnt_r <= 6'h00;
          if (en_sync_r[1])
            frame_r <= PVC_HEAD;
        end
        PVC_HEAD:
        begin
          if (!en_sync_r[1])
            frame_r <= PVC_IDLE;
          else if (clk_rise)
          begin
            hdr_r <= {hdr_r[6:0], dat_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 6'h01;
            if (bit_cnt_r + 6'h01 == `PVC_HDR_BITS)
              frame_r <= PVC_DATA;
          end
        end
        PVC_DATA:
        begin
          if (!en_sync_r[1])
            frame_r <= PVC_IDLE;
          else if (clk_rise && bit_cnt_r != `PVC_FRAME_BITS)
          begin
            data_r <= {data_r[22:0], dat_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 6'h01;
          end
        end
      endcase
    end
  end

  // readback shifter, drives while a read frame is in its data phase
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shout_r <= 24'h000000;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else if (frame_r == PVC_HEAD && clk_rise && bit_cnt_r + 6'h01 == `PVC_HDR_BITS)
    begin
      shout_r <= 24'h000000;
      sdo_oe_r <= hdr_r[6];
      if (hdr_r[6])
        {sdo_r, shout_r} <= {rd_word, 1'b0};
    end
    else if (frame_r == PVC_DATA && clk_rise && sdo_oe_r)
    begin
      sdo_r <= shout_r[23];
      shout_r <= {shout_r[22:0], 1'b0};
    end
    else if (frame_r != PVC_DATA)
    begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
  end

  // pump register reset, all bits stored
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      pump_r <= `PVC_RST_PUMP;
    else if (en_fall && wr_ok && hdr_r[6:1] == `PVC_ADDR_PUMP)
      pump_r <= data_r;
  end

  // calibration register reset, reserved bits kept
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      vcal_r <= `PVC_RST_VCAL;
    else if (en_fall && wr_ok && hdr_r[6:1] == `PVC_ADDR_VCAL)
      vcal_r <= data_r;
  end

  // enable held in its own flop so the pin carries no inverter
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      cal_en_r <= `PVC_RST_CAL_EN;
    else if (en_fall && wr_ok && hdr_r[6:1] == `PVC_ADDR_VCAL)
      cal_en_r <= !data_r[`PVC_VCAL_DIS_BIT];
  end

  // completed write to the vco access register
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      vco_wr_r <= 1'b0;
    else
      vco_wr_r <= en_fall && wr_ok && hdr_r[6:1] == `PVC_ADDR_VCO_ACCESS;
  end

  assign cal_bus.interval_code = vcal_r[`PVC_VCAL_INTV_MSB:`PVC_VCAL_INTV_LSB];
  assign cal_bus.clk_sel = vcal_r[`PVC_VCAL_CLKSEL_MSB:`PVC_VCAL_CLKSEL_LSB];
  assign cal_bus.cal_dis = vcal_r[`PVC_VCAL_DIS_BIT];
  assign cal_bus.no_trig = vcal_r[`PVC_VCAL_NOTRIG_BIT];
  assign cal_bus.vco_wr = vco_wr_r;
  assign cal_bus.meas_start = meas_start_i;
  assign cal_bus.rdiv_tick = rdiv_tick_i;

  pvc_cal_timing u_cal (
    .ref_clk_i (ref_clk_i),
    .reset_i (reset_i),
    .cal (cal_bus)
  );

  // pump current fields straight from register
  assign pump_dn_gain_o = pump_r[`PVC_PUMP_DN_MSB:`PVC_PUMP_DN_LSB];
  assign pump_up_gain_o = pump_r[`PVC_PUMP_UP_MSB:`PVC_PUMP_UP_LSB];
  assign pump_ofs_mag_o = pump_r[`PVC_PUMP_OFS_MSB:`PVC_PUMP_OFS_LSB];
  assign pump_ofs_up_en_o = pump_r[`PVC_PUMP_OFS_UP_BIT];
  assign pump_ofs_dn_en_o = pump_r[`PVC_PUMP_OFS_DN_BIT];
  // calibration enabled while disable bit clear
  assign cal_enable_o = cal_en_r;
  assign force_curve_o = vcal_r[`PVC_VCAL_FORCE_BIT];
  assign fsm_tick_o = cal_bus.fsm_tick;
  assign meas_done_o = cal_bus.meas_done;
  assign vco_internal_serial_port_xfer_o = cal_bus.xfer_req;
  assign ser_sdo_o = sdo_r;
  assign ser_sdo_oe_o = sdo_oe_r;
endmodule // pvc_regs

// ### logic/pvc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PVC_MAP_SVH
`define PVC_MAP_SVH

`define PVC_ADDR_W 6
`define PVC_DATA_W 24
`define PVC_ADDR_PUMP 6'h09
`define PVC_ADDR_VCAL 6'h0A
`define PVC_ADDR_VCO_ACCESS 6'h05
`define PVC_RST_PUMP 24'h403264
`define PVC_RST_VCAL 24'h002205
`define PVC_RST_CAL_EN 1'b1
`define PVC_HDR_BITS 6'h08
`define PVC_FRAME_BITS 6'h20

`define PVC_PUMP_DN_LSB 0
`define PVC_PUMP_DN_MSB 6
`define PVC_PUMP_UP_LSB 7
`define PVC_PUMP_UP_MSB 13
`define PVC_PUMP_OFS_LSB 14
`define PVC_PUMP_OFS_MSB 20
`define PVC_PUMP_OFS_UP_BIT 21
`define PVC_PUMP_OFS_DN_BIT 22

`define PVC_VCAL_INTV_LSB 0
`define PVC_VCAL_INTV_MSB 2
`define PVC_VCAL_FORCE_BIT 10
`define PVC_VCAL_DIS_BIT 11
`define PVC_VCAL_NOTRIG_BIT 12
`define PVC_VCAL_CLKSEL_LSB 13
`define PVC_VCAL_CLKSEL_MSB 14

`define PVC_DIV_TERM_0 5'h00
`define PVC_DIV_TERM_1 5'h03
`define PVC_DIV_TERM_2 5'h0F
`define PVC_DIV_TERM_3 5'h1F
`define PVC_INTV_MAX 9'h100

`endif

// ### logic/pvc_pkg.sv
// types shared by the pump and calibration configuration block
package pvc_pkg;
  typedef logic [23:0] pvc_word_t;
  typedef logic [2:0] pvc_intv_t;
  typedef logic [1:0] pvc_clksel_t;
  typedef logic [6:0] pvc_gain_t;
  typedef enum logic [2:0] {
    PVC_IDLE = 3'b001,
    PVC_HEAD = 3'b010,
    PVC_DATA = 3'b100
  } pvc_frame_t;
endpackage

// ### logic/pvc_cal_if.sv
// carrier between register bank and calibration timing
`timescale 1ns/1ps
interface pvc_cal_if;
  import pvc_pkg::*;
  pvc_intv_t interval_code;
  pvc_clksel_t clk_sel;
  logic cal_dis;
  logic no_trig;
  logic vco_wr;
  logic meas_start;
  logic rdiv_tick;
  logic fsm_tick;
  logic meas_done;
  logic xfer_req;
  modport regs (
    output interval_code, clk_sel, cal_dis, no_trig, vco_wr, meas_start, rdiv_tick,
    input fsm_tick, meas_done, xfer_req
  );
  modport cal (
    input interval_code, clk_sel, cal_dis, no_trig, vco_wr, meas_start, rdiv_tick,
    output fsm_tick, meas_done, xfer_req
  );
endinterface

// ### logic/pvc_cal_timing.sv
// calibration clock divider, measurement interval and transfer gating
`timescale 1ns/1ps
`include "pvc_map.svh"
module pvc_cal_timing (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  pvc_cal_if.cal cal
);
  import pvc_pkg::*;

  logic [4:0] div_cnt_r;
  logic [4:0] div_term;
  logic [8:0] intv_len;
  logic [8:0] intv_cnt_r;
  logic meas_busy_r;
  logic fsm_tick_r;
  logic meas_done_r;
  logic xfer_req_r;

  // divider terminal count from clock select code
  always_comb
  begin
    unique case (cal.clk_sel)
      2'h0: div_term = `PVC_DIV_TERM_0;
      2'h1: div_term = `PVC_DIV_TERM_1;
      2'h2: div_term = `PVC_DIV_TERM_2;
      2'h3: div_term = `PVC_DIV_TERM_3;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_cnt_r <= 5'h00;
      fsm_tick_r <= 1'b0;
    end
    else if (div_cnt_r >= div_term)
    begin
      div_cnt_r <= 5'h00;
      fsm_tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 5'h01;
      fsm_tick_r <= 1'b0;
    end
  end

  always_comb
  begin
    if (cal.interval_code == 3'h7)
      intv_len = `PVC_INTV_MAX;
    else
      intv_len = 9'h001 << cal.interval_code;
  end

  // count reference divider cycles, only while enabled
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meas_busy_r <= 1'b0;
      intv_cnt_r <= 9'h000;
      meas_done_r <= 1'b0;
    end
    else
    begin
      meas_done_r <= 1'b0;
      if (cal.cal_dis)
        meas_busy_r <= 1'b0;
      else if (!meas_busy_r && cal.meas_start)
      begin
        meas_busy_r <= 1'b1;
        intv_cnt_r <= 9'h000;
      end
      else if (meas_busy_r && cal.rdiv_tick)
      begin
        if (intv_cnt_r + 9'h001 >= intv_len)
        begin
          meas_busy_r <= 1'b0;
          meas_done_r <= 1'b1;
        end
        intv_cnt_r <= intv_cnt_r + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      xfer_req_r <= 1'b0;
    else
      xfer_req_r <= cal.vco_wr && !cal.no_trig;
  end

  assign cal.fsm_tick = fsm_tick_r;
  assign cal.meas_done = meas_done_r;
  assign cal.xfer_req = xfer_req_r;
endmodule // pvc_cal_timing

// ### bench/pvc_regs_chk.sv
// checker for the pump and calibration configuration outputs
`timescale 1ns/1ps
module pvc_regs_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ser_en_i,
  input wire logic rdiv_tick_i,
  input wire logic ser_sdo_oe_o,
  input wire pvc_pkg::pvc_gain_t pump_dn_gain_o,
  input wire pvc_pkg::pvc_gain_t pump_up_gain_o,
  input wire pvc_pkg::pvc_gain_t pump_ofs_mag_o,
  input wire logic pump_ofs_up_en_o,
  input wire logic pump_ofs_dn_en_o,
  input wire logic cal_enable_o,
  input wire logic force_curve_o,
  input wire logic fsm_tick_o,
  input wire logic meas_done_o,
  input wire logic vco_internal_serial_port_xfer_o
);
  import pvc_pkg::*;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // port idle long enough for any write to have landed
  sequence s_quiet;
    !ser_en_i [*8];
  endsequence
  // tick gap bounded by the slowest divider plus a changeover
  a_tick_period: assert property (fsm_tick_o |-> ##[1:40] fsm_tick_o)
    else $error("calibration tick gap too long");
  a_done_pulse: assert property (meas_done_o |=> !meas_done_o)
    else $error("measurement done wider than one cycle");
  a_done_cause: assert property (meas_done_o |-> $past(rdiv_tick_i))
    else $error("measurement done without divider tick");
  a_done_enabled: assert property (meas_done_o |-> cal_enable_o)
    else $error("measurement done while calibration off");
  a_xfer_pulse: assert property (vco_internal_serial_port_xfer_o
    |=> !vco_internal_serial_port_xfer_o)
    else $error("transfer launch wider than one cycle");
  a_pump_hold: assert property (s_quiet |=> $stable({pump_dn_gain_o, pump_up_gain_o,
    pump_ofs_mag_o, pump_ofs_up_en_o, pump_ofs_dn_en_o}))
    else $error("pump setting moved without a write");
  a_cal_hold: assert property (s_quiet |=> $stable({cal_enable_o, force_curve_o}))
    else $error("calibration setting moved without a write");
  a_oe_quiet: assert property (s_quiet |-> !ser_sdo_oe_o)
    else $error("readback driven outside a frame");
endmodule // pvc_regs_chk

bind pvc_regs pvc_regs_chk chk_u (.ref_clk_i, .reset_i, .ser_en_i, .rdiv_tick_i,
  .ser_sdo_oe_o, .pump_dn_gain_o, .pump_up_gain_o, .pump_ofs_mag_o, .pump_ofs_up_en_o,
  .pump_ofs_dn_en_o, .cal_enable_o, .force_curve_o, .fsm_tick_o, .meas_done_o,
  .vco_internal_serial_port_xfer_o);

// ### bench/pvc_regs_test.sv
// self-checking bench for the pump and calibration register block
`timescale 1ns/1ps
`include "pvc_map.svh"
module pvc_regs_test;
  import pvc_pkg::*;
  logic ref_clk_i, reset_i, ser_clk_i, ser_data_i, ser_en_i, rdiv_tick_i, meas_start_i;
  logic ser_sdo_o, ser_sdo_oe_o, pump_ofs_up_en_o, pump_ofs_dn_en_o, cal_enable_o;
  logic force_curve_o, fsm_tick_o, meas_done_o, vco_internal_serial_port_xfer_o;
  pvc_gain_t pump_dn_gain_o, pump_up_gain_o, pump_ofs_mag_o;
  int fails, checks, cyc, xfers, x0;
  logic [23:0] q;
  logic [8:0] n;
  logic [5:0] p;
  int tp [4] = '{1, 4, 16, 32};
  // only the first row sets both offset enables, to prove storage
  logic [5:0] ra [5] = '{`PVC_ADDR_PUMP, `PVC_ADDR_PUMP, `PVC_ADDR_VCAL, `PVC_ADDR_VCAL, 6'h3F};
  logic [23:0] rw [5] = '{24'hFFFFFF, 24'h800000, 24'h002047, 24'h01F800, 24'h123456};
  logic [23:0] re [5] = '{24'hFFFFFF, 24'h800000, 24'h002047, 24'h01F800, 24'h000000};

  pvc_regs dut_u (.ref_clk_i, .reset_i, .ser_clk_i, .ser_data_i, .ser_en_i, .ser_sdo_o,
    .ser_sdo_oe_o, .rdiv_tick_i, .meas_start_i, .pump_dn_gain_o, .pump_up_gain_o,
    .pump_ofs_mag_o, .pump_ofs_up_en_o, .pump_ofs_dn_en_o, .cal_enable_o, .force_curve_o,
    .fsm_tick_o, .meas_done_o, .vco_internal_serial_port_xfer_o);

  // 40 MHz reference keeps every divided clock under 50 MHz
  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // cycle ceiling and count of transfer launches
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (vco_internal_serial_port_xfer_o === 1'b1) xfers <= xfers + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      final_report();
    end
  end

  task chk(input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task final_report();
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one serial frame of n bits, readback bits sampled before each rise
  task xfer(input logic rd, input logic [5:0] a, input logic [23:0] d, input int n,
    output logic [23:0] r);
    logic [31:0] w;
    w = {rd, a, 1'b0, d};
    r = 24'h000000;
    ser_en_i <= 1'b1;
    for (int i = 31; i > 31 - n; i--)
    begin
      ser_data_i <= w[i];
      repeat (4) @(posedge ref_clk_i);
      if (i < 24) r[i] = ser_sdo_o;
      if (i == 23) chk(24'(ser_sdo_oe_o), 24'(rd));
      ser_clk_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ser_clk_i <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    ser_en_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask

  task wr(input logic [5:0] a, input logic [23:0] d);
    xfer(1'b0, a, d, 32, q);
  endtask

  task rdv(input logic [5:0] a, output logic [23:0] r);
    xfer(1'b1, a, 24'h000000, 32, r);
  endtask

  // start a measurement and count divider ticks until done
  task meas(input int lim, output logic [8:0] k);
    logic d;
    meas_start_i <= 1'b1;
    @(posedge ref_clk_i);
    meas_start_i <= 1'b0;
    k = 0;
    d = 1'b0;
    while (d !== 1'b1 && k < lim)
    begin
      rdiv_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      rdiv_tick_i <= 1'b0;
      k++;
      @(negedge ref_clk_i);
      d = meas_done_o;
      @(posedge ref_clk_i);
    end
  endtask

  // cycles until the next calibration tick
  task period(output logic [5:0] g);
    g = 0;
    do
    begin
      @(negedge ref_clk_i);
      g++;
    end
    while (fsm_tick_o !== 1'b1 && g < 40);
  endtask

  initial
  begin
    {reset_i, ser_clk_i, ser_data_i, ser_en_i, rdiv_tick_i, meas_start_i} = 6'h20;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    // table rows: write, read back, check decoded outputs
    for (int i = 0; i < 5; i++)
    begin
      wr(ra[i], rw[i]);
      rdv(ra[i], q);
      chk(q, re[i]);
      if (ra[i] == `PVC_ADDR_PUMP)
        chk(24'({pump_ofs_dn_en_o, pump_ofs_up_en_o, pump_ofs_mag_o, pump_up_gain_o,
          pump_dn_gain_o}), 24'(rw[i][22:0]));
      if (ra[i] == `PVC_ADDR_VCAL)
        chk(24'({cal_enable_o, force_curve_o}), 24'({~rw[i][11], rw[i][10]}));
    end
    // frame cut short writes nothing
    xfer(1'b0, `PVC_ADDR_PUMP, 24'h000001, 24, q);
    rdv(`PVC_ADDR_PUMP, q);
    chk(q, 24'h800000);
    // transfer launch with and without suppression
    wr(`PVC_ADDR_VCAL, 24'h002047);
    x0 = xfers;
    wr(6'h05, 24'h000000);
    chk(24'(xfers - x0), 24'h000001);
    wr(`PVC_ADDR_VCAL, 24'h003047);
    x0 = xfers;
    wr(6'h05, 24'h000000);
    chk(24'(xfers - x0), 24'h000000);
    // divided calibration clock for each select code
    for (int c = 0; c < 4; c++)
    begin
      wr(`PVC_ADDR_VCAL, {9'h000, c[1:0], 13'h0047});
      period(p);
      period(p);
      chk(24'(p), 24'(tp[c]));
    end
    // measurement interval for each code
    for (int c = 0; c < 8; c++)
    begin
      wr(`PVC_ADDR_VCAL, 24'h002040 | 24'(c));
      meas(300, n);
      chk(24'(n), c == 7 ? 24'h000100 : 24'(1 << c));
    end
    // disabled calibration ignores a start
    wr(`PVC_ADDR_VCAL, 24'h002840);
    meas(8, n);
    chk(24'(n), 24'h000008);
    // reset in mid-run restores defaults
    reset_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({pump_ofs_dn_en_o, pump_ofs_up_en_o, pump_ofs_mag_o, pump_up_gain_o,
      pump_dn_gain_o, cal_enable_o}, {23'h403264, 1'b1});
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rdv(`PVC_ADDR_PUMP, q);
    chk(q, 24'h403264);
    rdv(`PVC_ADDR_VCAL, q);
    chk(q, 24'h002205);
    period(p);
    period(p);
    chk(24'(p), 24'h000004);
    final_report();
  end
endmodule // pvc_regs_test
